/* File: src/plsup_defs.svh */
`ifndef PLSUP_DEFS_SVH
`define PLSUP_DEFS_SVH
// Register byte offsets
`define PLSUP_OFF_CTRL 12'h000
`define PLSUP_OFF_VLOW 12'h004
`define PLSUP_OFF_ILOAD 12'h008
`define PLSUP_OFF_IRES 12'h00c
`define PLSUP_OFF_DELAY 12'h010
`define PLSUP_OFF_STATUS 12'h014
`define PLSUP_OFF_IRQ_STAT 12'h018
`define PLSUP_OFF_IRQ_EN 12'h01c
`define PLSUP_OFF_IRQ_CLR 12'h020
// Control bits
`define PLSUP_CTRL_BLK_EN 0
`define PLSUP_CTRL_BRK_ASSIGN 1
`define PLSUP_CTRL_EVT_USE 2
`define PLSUP_CTRL_PVT_USE 3
`define PLSUP_CTRL_CT_SIDE 4
// Ratio: neg/pos above 40 percent, as neg*100 > pos*40
`define PLSUP_RATIO_NUM 8'd100
`define PLSUP_RATIO_DEN 8'd40
// Reset values
`define PLSUP_CTRL_RST 32'h0000_0000
`define PLSUP_DELAY_RST 32'h0000_0064
// Bus answers
`define PLSUP_RESP_OKAY 2'b00
`define PLSUP_RESP_SLVERR 2'b10
`endif

/* File: src/plsup_pkg.sv */
package plsup_pkg;
  parameter int MW = 16;
  typedef struct packed {
    logic [MW-1:0] v1;
    logic [MW-1:0] v2;
    logic [MW-1:0] v3;
    logic [MW-1:0] v0;
    logic [MW-1:0] vneg;
    logic [MW-1:0] vpos;
  } plsup_volt_t;
  typedef struct packed {
    logic [MW-1:0] i1;
    logic [MW-1:0] i2;
    logic [MW-1:0] i3;
    logic [MW-1:0] i0;
  } plsup_curr_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TIMING = 2'b01,
    ST_BLOCK = 2'b10
  } plsup_state_t;
endpackage

/* File: src/plsup_top.sv */
// Functional notes
// R1: Earth VT breaker input, when used, trips the voltage-loss block as fuse failure.
// R2: Measured block asserts only when every qualifying condition holds together.
// R3: Qualify when any phase voltage is below one hundredth of rated.
// R4: Qualify when residual voltage low or negative/positive ratio above forty percent.
// R5: Qualify when all three phase currents are below the load threshold.
// R6: Qualify when residual current is below one tenth of rated current.
// R7: Qualify only when no inhibiting overcurrent element is picked up.
// R8: Breaker must be closed when assigned; ignored when unassigned.
// R9: Qualify only when offline detection reports no dead busbar.
// R10: Supervised protective elements are blocked while the block command stands.
// R11: Fuse-failure input going dead blocks all supervised elements.
// R12: Currents come from the CT on the side of the VT.
// R13: Block alarm issues only after the alarm delay with condition present.
// R14: Blocking of elements happens only while block enable is active.
// R15: Evaluation, counter and outputs are registered and cleared by synchronous reset.
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`include "plsup_defs.svh"
module plsup_top #(
  parameter int NELEM = 8,
  parameter int NOC = 4
) (
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Measurement front end
  input wire plsup_pkg::plsup_volt_t volt,
  input wire plsup_pkg::plsup_curr_t curr_a,
  input wire plsup_pkg::plsup_curr_t curr_b,
  // Pins from outside domain
  input wire logic earth_vt_fuse_fail_input,
  input wire logic phase_vt_fuse_fail_input,
  input wire logic breaker_closed,
  input wire logic [NOC-1:0] oc_pickup,
  input wire logic dead_busbar,
  // Element supervision settings
  input wire logic [NELEM-1:0] elem_mcs_active,
  // Outputs
  output logic voltage_loss_block,
  output logic [NELEM-1:0] elem_block,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  import plsup_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NS = NOC + 4;
  logic [NS-1:0] sy1_ff, sy2_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sy1_ff <= '0;
      sy2_ff <= '0;
    end else if (clk_en) begin
      sy1_ff <= {oc_pickup, dead_busbar, breaker_closed,
                 phase_vt_fuse_fail_input, earth_vt_fuse_fail_input};
      sy2_ff <= sy1_ff;
    end
  end
  logic evt_ff_s, pvt_ff_s, brk_s, dead_s;
  logic [NOC-1:0] oc_s;
  assign evt_ff_s = sy2_ff[0];
  assign pvt_ff_s = sy2_ff[1];
  assign brk_s = sy2_ff[2];
  assign dead_s = sy2_ff[3];
  assign oc_s = sy2_ff[NS-1:4];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] ctrl_ff, vlow_ff, iload_ff, ires_ff, delay_ff;
  logic [1:0] irq_stat_ff, irq_en_ff;
  logic aw_ok, w_ok, wr_go, rd_go;
  logic [1:0] clr_req;
  assign wr_go = s_awvalid && s_wvalid && !s_bvalid && clk_en;
  assign rd_go = s_arvalid && !s_rvalid && clk_en;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a <= `PLSUP_OFF_IRQ_CLR) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_ff <= `PLSUP_CTRL_RST;
      vlow_ff <= '0;
      iload_ff <= '0;
      ires_ff <= '0;
      delay_ff <= `PLSUP_DELAY_RST;
      irq_en_ff <= '0;
    end else if (wr_go) begin
      unique case (s_awaddr)
        `PLSUP_OFF_CTRL: ctrl_ff <= merge(ctrl_ff, s_wdata, s_wstrb);
        `PLSUP_OFF_VLOW: vlow_ff <= merge(vlow_ff, s_wdata, s_wstrb);
        `PLSUP_OFF_ILOAD: iload_ff <= merge(iload_ff, s_wdata, s_wstrb);
        `PLSUP_OFF_IRES: ires_ff <= merge(ires_ff, s_wdata, s_wstrb);
        `PLSUP_OFF_DELAY: delay_ff <= merge(delay_ff, s_wdata, s_wstrb);
        `PLSUP_OFF_IRQ_EN: if (s_wstrb[0]) irq_en_ff <= s_wdata[1:0];
        default: ;
      endcase
    end
  end
  assign clr_req = (wr_go && s_awaddr == `PLSUP_OFF_IRQ_CLR && s_wstrb[0]) ?
                   s_wdata[1:0] : 2'b00;

  // Write channel: address and data taken together
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= `PLSUP_RESP_OKAY;
    end else if (clk_en) begin
      s_awready <= wr_go;
      s_wready <= wr_go;
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp <= mapped(s_awaddr) ? `PLSUP_RESP_OKAY : `PLSUP_RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Qualifying conditions
  // ----------------------------------------
  plsup_curr_t cur;
  logic c_vlow, c_res, c_iload, c_ires, c_noc, c_brk, c_live, meas_ok;
  logic [2*MW+7:0] neg_scaled, pos_scaled;
  always_comb begin
    cur = ctrl_ff[`PLSUP_CTRL_CT_SIDE] ? curr_b : curr_a; // R12
    // Widen before the product so large magnitudes do not wrap
    neg_scaled = (2*MW+8)'(volt.vneg) * `PLSUP_RATIO_NUM;
    pos_scaled = (2*MW+8)'(volt.vpos) * `PLSUP_RATIO_DEN;
    c_vlow = (volt.v1 < vlow_ff[MW-1:0]) || (volt.v2 < vlow_ff[MW-1:0])
             || (volt.v3 < vlow_ff[MW-1:0]); // R3
    c_res = (volt.v0 < vlow_ff[MW-1:0]) || (neg_scaled > pos_scaled); // R4
    c_iload = (cur.i1 < iload_ff[MW-1:0]) && (cur.i2 < iload_ff[MW-1:0])
              && (cur.i3 < iload_ff[MW-1:0]); // R5
    c_ires = cur.i0 < ires_ff[MW-1:0]; // R6
    c_noc = ~|oc_s; // R7
    c_brk = !ctrl_ff[`PLSUP_CTRL_BRK_ASSIGN] || brk_s; // R8
    c_live = !dead_s; // R9
    meas_ok = c_vlow && c_res && c_iload && c_ires && c_noc && c_brk && c_live; // R2
  end

  logic meas_ff, fuse_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meas_ff <= 1'b0;
      fuse_ff <= 1'b0;
    end else if (clk_en) begin
      meas_ff <= meas_ok; // R15
      fuse_ff <= (ctrl_ff[`PLSUP_CTRL_EVT_USE] && evt_ff_s) // R1
                 || (ctrl_ff[`PLSUP_CTRL_PVT_USE] && pvt_ff_s); // R11
    end
  end

  // ----------------------------------------
  // Alarm delay state machine
  // ----------------------------------------
  plsup_state_t st_ff;
  logic [31:0] cnt_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
    end else if (clk_en) begin
      unique case (st_ff)
        ST_IDLE: begin
          cnt_ff <= '0;
          if (meas_ff) st_ff <= ST_TIMING;
        end
        ST_TIMING: begin
          if (!meas_ff) begin
            st_ff <= ST_IDLE;
          end else if (cnt_ff + 32'd1 >= delay_ff) begin
            st_ff <= ST_BLOCK; // R13
          end else begin
            cnt_ff <= cnt_ff + 32'd1;
          end
        end
        ST_BLOCK: if (!meas_ff) st_ff <= ST_IDLE;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Outputs and interrupts
  // ----------------------------------------
  logic nxt_blk;
  assign nxt_blk = (st_ff == ST_BLOCK) || fuse_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      voltage_loss_block <= 1'b0;
      elem_block <= '0;
    end else if (clk_en) begin
      voltage_loss_block <= nxt_blk; // R15
      elem_block <= (ctrl_ff[`PLSUP_CTRL_BLK_EN] && nxt_blk) ? // R14
                    elem_mcs_active : '0; // R10
    end
  end

  // Bit 0 block rise, bit 1 fuse-fail rise; set wins over clear
  logic [1:0] ev;
  assign ev = {fuse_ff && !voltage_loss_block, nxt_blk && !voltage_loss_block};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_ff <= '0;
      irq <= 1'b0;
    end else if (clk_en) begin
      irq_stat_ff <= (irq_stat_ff & ~clr_req) | ev;
      irq <= |(((irq_stat_ff & ~clr_req) | ev) & irq_en_ff);
    end
  end

  // Read channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= `PLSUP_RESP_OKAY;
    end else if (clk_en) begin
      s_arready <= rd_go;
      if (rd_go) begin
        s_rvalid <= 1'b1;
        s_rresp <= mapped(s_araddr) ? `PLSUP_RESP_OKAY : `PLSUP_RESP_SLVERR;
        unique case (s_araddr)
          `PLSUP_OFF_CTRL: s_rdata <= ctrl_ff;
          `PLSUP_OFF_VLOW: s_rdata <= vlow_ff;
          `PLSUP_OFF_ILOAD: s_rdata <= iload_ff;
          `PLSUP_OFF_IRES: s_rdata <= ires_ff;
          `PLSUP_OFF_DELAY: s_rdata <= delay_ff;
          `PLSUP_OFF_STATUS: s_rdata <= {27'h0, st_ff, fuse_ff, meas_ff,
                                         voltage_loss_block};
          `PLSUP_OFF_IRQ_STAT: s_rdata <= {30'h0, irq_stat_ff};
          `PLSUP_OFF_IRQ_EN: s_rdata <= {30'h0, irq_en_ff};
          default: s_rdata <= '0;
        endcase
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_fuse_blocks: assert property (@(posedge clk) disable iff (sys_rst) // R1
    (clk_en && fuse_ff) |=> voltage_loss_block)
    else $error("fuse failure did not block");
  a_meas_all: assert property (@(posedge clk) disable iff (sys_rst) // R2
    (clk_en && !meas_ok) |=> !meas_ff)
    else $error("measured qualifier set with a failed condition");
  a_vlow_need: assert property (@(posedge clk) disable iff (sys_rst) // R3
    (volt.v1 >= vlow_ff[MW-1:0] && volt.v2 >= vlow_ff[MW-1:0]
     && volt.v3 >= vlow_ff[MW-1:0]) |-> !meas_ok)
    else $error("qualified without low phase voltage");
  a_noc_need: assert property (@(posedge clk) disable iff (sys_rst) // R7
    (|oc_s) |-> !meas_ok)
    else $error("qualified with overcurrent pickup");
  a_brk_need: assert property (@(posedge clk) disable iff (sys_rst) // R8
    (ctrl_ff[`PLSUP_CTRL_BRK_ASSIGN] && !brk_s) |-> !meas_ok)
    else $error("qualified with assigned breaker open");
  a_dead_need: assert property (@(posedge clk) disable iff (sys_rst) // R9
    dead_s |-> !meas_ok)
    else $error("qualified on dead busbar");
  a_delay_hold: assert property (@(posedge clk) disable iff (sys_rst) // R13
    (st_ff == ST_IDLE && !fuse_ff && clk_en) |=> !voltage_loss_block)
    else $error("block issued before delay");
  a_enable_gate: assert property (@(posedge clk) disable iff (sys_rst) // R14
    (clk_en && !ctrl_ff[`PLSUP_CTRL_BLK_EN]) |=> (elem_block == '0))
    else $error("elements blocked while disabled");
  a_elem_follow: assert property (@(posedge clk) disable iff (sys_rst) // R10
    (clk_en && ctrl_ff[`PLSUP_CTRL_BLK_EN] && nxt_blk) |=>
    (elem_block == $past(elem_mcs_active)))
    else $error("supervised element not blocked");
  c_meas_block: cover property (@(posedge clk) st_ff == ST_TIMING ##1 st_ff == ST_BLOCK);
  c_fuse_block: cover property (@(posedge clk) fuse_ff ##1 voltage_loss_block);
  c_abort: cover property (@(posedge clk) st_ff == ST_TIMING ##1 st_ff == ST_IDLE);
endmodule // plsup_top

/* File: sim/plsup_front_model.sv */
module plsup_front_model (
  // Scenario select
  input wire logic [3:0] fault_sel,
  // Measured quantities
  output plsup_pkg::plsup_volt_t volt,
  output plsup_pkg::plsup_curr_t curr_a,
  output plsup_pkg::plsup_curr_t curr_b,
  // Plant status
  output logic breaker_closed,
  output logic [3:0] oc_pickup,
  output logic dead_busbar
);
  import plsup_pkg::*;
  // Cases 0, 8 and 10-15 meet every loss condition (8 through the ratio); cases 1-7 and 9 break one (6 only with the breaker assigned, 9 only on CT side A)
  always_comb begin
    volt = '{16'h0032, 16'h2710, 16'h2710, 16'h0032, 16'h0000, 16'h2710};
    curr_b = '{16'h01f4, 16'h01f4, 16'h01f4, 16'h0032};
    curr_a = curr_b;
    breaker_closed = 1'b1;
    oc_pickup = 4'h0;
    dead_busbar = 1'b0;
    case (fault_sel)
      4'h1: volt.v1 = 16'h2710;
      4'h2: volt.v0 = 16'h00c8;
      4'h3: begin
        curr_a.i2 = 16'h07d0;
        curr_b.i2 = 16'h07d0;
      end
      4'h4: begin
        curr_a.i0 = 16'h00c8;
        curr_b.i0 = 16'h00c8;
      end
      4'h5: oc_pickup = 4'h4;
      4'h6: breaker_closed = 1'b0;
      4'h7: dead_busbar = 1'b1;
      4'h8: begin
        volt.v0 = 16'h00c8;
        volt.vneg = 16'h1388;
      end
      4'h9: curr_a.i1 = 16'h07d0;
      default: ;
    endcase
  end
endmodule // plsup_front_model

/* File: sim/test_potential_loss_supervision.sv */
`include "plsup_defs.svh"
module test_potential_loss_supervision;
  timeunit 1ns;
  timeprecision 1ps;
  import plsup_pkg::*;
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
  logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
  plsup_volt_t volt;
  plsup_curr_t curr_a, curr_b;
  logic earth_vt_fuse_fail_input = 1'b0, phase_vt_fuse_fail_input = 1'b0;
  logic breaker_closed, dead_busbar, voltage_loss_block, irq;
  logic [3:0] oc_pickup, fault_sel = 4'h1, s_wstrb = 4'hf;
  logic [7:0] elem_mcs_active = 8'ha5, elem_block;
  logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
  logic [31:0] s_wdata = 32'h0, s_rdata, rd_v;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, rd_r;
  int n_errors = 0, cmp_count = 0;

  plsup_top u_dut (.*);
  plsup_front_model u_front (.*);

  always #2.5 clk = ~clk;

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    s_bready <= 1'b0;
    `CHK("bresp", er, s_bresp)
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    rd_v = s_rdata;
    rd_r = s_rresp;
    s_rready <= 1'b0;
    `CHK("rresp", er, rd_r)
    `CHK("rdata", d, rd_v)
  endtask

  task automatic run_case(input logic [3:0] k, input logic [31:0] ctrl, input logic e);
    wr(`PLSUP_OFF_CTRL, ctrl, `PLSUP_RESP_OKAY);
    fault_sel <= k;
    repeat (60) @(posedge clk);
    `CHK("block", e, voltage_loss_block)
    fault_sel <= 4'h1;
    repeat (12) @(posedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(`PLSUP_OFF_CTRL, `PLSUP_CTRL_RST, `PLSUP_RESP_OKAY);
    rd(`PLSUP_OFF_DELAY, `PLSUP_DELAY_RST, `PLSUP_RESP_OKAY);
    `CHK("block", 1'b0, voltage_loss_block)
    rd(12'h100, 32'h0, `PLSUP_RESP_SLVERR);
    wr(12'h100, 32'h1, `PLSUP_RESP_SLVERR);
    wr(`PLSUP_OFF_DELAY, 32'h14, `PLSUP_RESP_OKAY);
    wr(`PLSUP_OFF_VLOW, 32'h64, `PLSUP_RESP_OKAY);
    wr(`PLSUP_OFF_ILOAD, 32'h3e8, `PLSUP_RESP_OKAY);
    wr(`PLSUP_OFF_IRES, 32'h64, `PLSUP_RESP_OKAY);
    $display("test regs done");
  endtask

  task automatic t_conds;
    for (int k = 0; k < 10; k++) begin
      run_case(k[3:0], 32'h3, (k == 0) || (k == 8));
    end
    run_case(4'h6, 32'h1, 1'b1);
    run_case(4'h9, 32'h11, 1'b1);
    $display("test conds done");
  endtask

  task automatic t_delay;
    wr(`PLSUP_OFF_CTRL, 32'h1, `PLSUP_RESP_OKAY);
    fault_sel <= 4'h0;
    repeat (10) @(posedge clk);
    `CHK("early", 1'b0, voltage_loss_block)
    repeat (50) @(posedge clk);
    `CHK("late", 1'b1, voltage_loss_block)
    `CHK("elem", elem_mcs_active, elem_block)
    wr(`PLSUP_OFF_CTRL, 32'h0, `PLSUP_RESP_OKAY);
    repeat (3) @(posedge clk);
    `CHK("elem_off", 8'h00, elem_block)
    fault_sel <= 4'h1;
    repeat (12) @(posedge clk);
    $display("test delay done");
  endtask

  task automatic t_fuse;
    wr(`PLSUP_OFF_IRQ_EN, 32'h3, `PLSUP_RESP_OKAY);
    wr(`PLSUP_OFF_IRQ_CLR, 32'h3, `PLSUP_RESP_OKAY);
    wr(`PLSUP_OFF_CTRL, 32'h1, `PLSUP_RESP_OKAY);
    earth_vt_fuse_fail_input <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("unused", 1'b0, voltage_loss_block)
    wr(`PLSUP_OFF_CTRL, 32'h5, `PLSUP_RESP_OKAY);
    repeat (8) @(posedge clk);
    `CHK("evt", 1'b1, voltage_loss_block)
    `CHK("elem", elem_mcs_active, elem_block)
    `CHK("irq", 1'b1, irq)
    rd(`PLSUP_OFF_IRQ_STAT, 32'h3, `PLSUP_RESP_OKAY);
    wr(`PLSUP_OFF_IRQ_EN, 32'h0, `PLSUP_RESP_OKAY);
    @(posedge clk);
    `CHK("masked", 1'b0, irq)
    earth_vt_fuse_fail_input <= 1'b0;
    wr(`PLSUP_OFF_CTRL, 32'h9, `PLSUP_RESP_OKAY);
    phase_vt_fuse_fail_input <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("pvt", 1'b1, voltage_loss_block)
    phase_vt_fuse_fail_input <= 1'b0;
    repeat (8) @(posedge clk);
    wr(`PLSUP_OFF_IRQ_CLR, 32'h3, `PLSUP_RESP_OKAY);
    rd(`PLSUP_OFF_IRQ_STAT, 32'h0, `PLSUP_RESP_OKAY);
    wr(`PLSUP_OFF_IRQ_EN, 32'h3, `PLSUP_RESP_OKAY);
    @(posedge clk);
    `CHK("cleared", 1'b0, irq)
    $display("test fuse done");
  endtask

  task automatic t_hold;
    wr(`PLSUP_OFF_CTRL, 32'h5, `PLSUP_RESP_OKAY);
    clk_en <= 1'b0;
    earth_vt_fuse_fail_input <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("frozen", 1'b0, voltage_loss_block)
    clk_en <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("thawed", 1'b1, voltage_loss_block)
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("rst_blk", 1'b0, voltage_loss_block)
    `CHK("rst_elem", 8'h00, elem_block)
    sys_rst <= 1'b0;
    rd(`PLSUP_OFF_CTRL, `PLSUP_CTRL_RST, `PLSUP_RESP_OKAY);
    repeat (8) @(posedge clk);
    `CHK("rst_evt", 1'b0, voltage_loss_block)
    earth_vt_fuse_fail_input <= 1'b0;
    $display("test hold done");
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #50000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_conds();
    t_delay();
    t_fuse();
    t_hold();
    tally_and_finish();
  end
endmodule // test_potential_loss_supervision
